// [gpp_port.sv]
// eight-pin port with direction, mode, alternate functions and event request
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - eight pins, each independently input, interrupt input, or output
// R2 - bit x of every port register belongs to pin x
// R3 - direction clear: pin is input, level reads return pin level
// R4 - level writes on input pins only store the latch
// R5 - input mode bit picks floating or pull-up; high driver off
// R6 - direction,mode: 00 float, 01 pull-up/irq, 10 open-drain, 11 push-pull
// R7 - interrupt inputs raise external request independently
// R8 - events qualified by group sense setting, then ORed to one request
// R9 - request latch hidden from software, cleared on vector fetch
// R10 - changing sense setting discards pending request
// R11 - direction set: pin driven from latch; reads return latch
// R12 - output mode bit: push-pull or open-drain; 1 floats in open-drain
// R13 - peripheral use selects alternate function, overriding port setting
// R14 - peripheral-driven pin becomes output, drive kind from peripheral
// R15 - pin feeding a peripheral is input; level still readable
// R16 - input pin with alternate output enabled reads alternate output
// R17 - output pin with alternate input enabled feeds latch to peripheral
// R18 - software writes latch before switching pin to output
// R19 - software avoids single-bit read-modify-write on latch
// R20 - software keeps alternate function off on interrupt inputs
// R21 - bidirectional peripheral pins left floating input by software
// R22 - pin inputs pass two-stage synchroniser before use
module gpp_port (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic [gpp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [gpp_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [gpp_pkg::DATA_W-1:0] RDATA,
    input wire logic [gpp_pkg::PIN_W-1:0] PIN_IN,
    output logic [gpp_pkg::PIN_W-1:0] PIN_OUT,
    output logic [gpp_pkg::PIN_W-1:0] PIN_OE,
    output logic [gpp_pkg::PIN_W-1:0] PIN_PULLUP,
    input wire logic [gpp_pkg::PIN_W-1:0] ALT_OUT_EN,
    input wire logic [gpp_pkg::PIN_W-1:0] ALT_OUT,
    input wire logic [gpp_pkg::PIN_W-1:0] ALT_OPEN_DRAIN,
    input wire logic [gpp_pkg::PIN_W-1:0] ALT_IN_EN,
    output logic [gpp_pkg::PIN_W-1:0] ALT_IN,
    input wire logic VEC_FETCH,
    output logic EXT_IRQ
);
    import gpp_pkg::*;

    // ************************************************
    // register file
    // ************************************************
    logic [PIN_W-1:0] level_reg, level_next;
    logic [PIN_W-1:0] dir_reg, dir_next;
    logic [PIN_W-1:0] mode_reg, mode_next;
    logic [SENSE_W-1:0] sense_reg, sense_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [PIN_W-1:0] pin_seen;
    logic sense_chg;

    always_comb begin
        level_next = level_reg;
        dir_next = dir_reg;
        mode_next = mode_reg;
        sense_next = sense_reg;
        rdata_next = rdata_reg;
        if (WR) begin
            unique case (ADDR)
                ADDR_LEVEL: level_next = WDATA; // R4
                ADDR_DIR: dir_next = WDATA; // R2
                ADDR_MODE: mode_next = WDATA; // R2
                ADDR_SENSE: sense_next = WDATA[SENSE_W-1:0];
            endcase
        end
        if (RD) begin
            unique case (ADDR)
                ADDR_LEVEL: rdata_next = pin_seen; // R3 R11 R15 R16
                ADDR_DIR: rdata_next = dir_reg;
                ADDR_MODE: rdata_next = mode_reg;
                ADDR_SENSE: rdata_next = {{(DATA_W-SENSE_W){1'b0}}, sense_reg};
            endcase
        end
    end

    assign sense_chg = WR && (ADDR == ADDR_SENSE) && (WDATA[SENSE_W-1:0] != sense_reg);

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            level_reg <= RST_PORT;
            dir_reg <= RST_PORT;
            mode_reg <= RST_PORT;
            sense_reg <= RST_SENSE;
            rdata_reg <= RST_PORT;
        end else begin
            level_reg <= level_next;
            dir_reg <= dir_next;
            mode_reg <= mode_next;
            sense_reg <= sense_next;
            rdata_reg <= rdata_next;
        end
    end
    assign RDATA = rdata_reg;

    // ************************************************
    // input synchroniser
    // ************************************************
    logic [PIN_W-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next, prev_reg, prev_next;

    always_comb begin
        sync1_next = PIN_IN; // R22
        sync2_next = sync1_reg; // R22
        prev_next = sync2_reg;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_reg <= RST_PORT;
            sync2_reg <= RST_PORT;
            prev_reg <= RST_PORT;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
        end
    end

    // ************************************************
    // pin drivers
    // ************************************************
    logic [PIN_W-1:0] irq_sel;
    logic [PIN_W-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
    logic [PIN_W-1:0] pull_reg, pull_next, alt_in_reg, alt_in_next;

    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
        always_comb begin
            if (ALT_OUT_EN[i]) begin
                pin_out_next[i] = ALT_OUT[i]; // R13 R14
                pin_oe_next[i] = !(ALT_OPEN_DRAIN[i] && ALT_OUT[i]); // R14
                pull_next[i] = 1'b0;
            end else if (dir_reg[i]) begin
                pin_out_next[i] = level_reg[i]; // R11
                pin_oe_next[i] = mode_reg[i] || !level_reg[i]; // R12 R6
                pull_next[i] = 1'b0;
            end else begin
                pin_out_next[i] = 1'b0; // R3
                pin_oe_next[i] = 1'b0; // R5
                pull_next[i] = mode_reg[i]; // R5 R6
            end
            alt_in_next[i] = dir_reg[i] ? level_reg[i] : sync2_reg[i]; // R17 R15
            pin_seen[i] = dir_reg[i] ? level_reg[i]
                        : (ALT_OUT_EN[i] ? ALT_OUT[i] : sync2_reg[i]); // R16 R3
            irq_sel[i] = IRQ_CAPABLE[i] && !dir_reg[i] && mode_reg[i]; // R7 R1
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_out_reg <= RST_PORT;
            pin_oe_reg <= RST_PORT;
            pull_reg <= RST_PORT;
            alt_in_reg <= RST_PORT;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            pull_reg <= pull_next;
            alt_in_reg <= alt_in_next;
        end
    end
    assign PIN_OUT = pin_out_reg;
    assign PIN_OE = pin_oe_reg;
    assign PIN_PULLUP = pull_reg;
    assign ALT_IN = alt_in_reg;

    // ************************************************
    // event detection and request latch
    // ************************************************
    function automatic logic qualify(input logic [SENSE_W-1:0] s, input logic cur,
                                     input logic old);
        unique case (gpp_sense_e'(s))
            GPP_SENSE_FALL_LOW: qualify = !cur;
            GPP_SENSE_RISE: qualify = cur && !old;
            GPP_SENSE_FALL: qualify = !cur && old;
            GPP_SENSE_BOTH: qualify = cur != old;
        endcase
    endfunction : qualify

    logic [PIN_W-1:0] ev;
    logic any_ev;
    logic irq_reg, irq_next;

    always_comb begin
        for (int k = 0; k < PIN_W; k++) begin
            ev[k] = irq_sel[k] && qualify(sense_reg, sync2_reg[k], prev_reg[k]); // R8
        end
        any_ev = |ev; // R8
        irq_next = irq_reg;
        if (VEC_FETCH) begin
            irq_next = 1'b0; // R9
        end
        if (any_ev) begin
            irq_next = 1'b1; // R7
        end
        if (sense_chg) begin
            irq_next = 1'b0; // R10
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end
    assign EXT_IRQ = irq_reg;

    // ************************************************
    // checks
    // ************************************************
    property p_rd_dir;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (RD && ADDR == ADDR_DIR) |=> (RDATA == $past(dir_reg));
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("dir readback wrong"); // R2

    property p_rd_in;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (RD && ADDR == ADDR_LEVEL && dir_reg == RST_PORT && ALT_OUT_EN == RST_PORT)
            |=> (RDATA == $past(sync2_reg));
    endproperty
    a_rd_in: assert property (p_rd_in) else $error("input readback wrong"); // R3

    property p_in_nodrive;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (!dir_reg[0] && !ALT_OUT_EN[0]) |=> !PIN_OE[0];
    endproperty
    a_in_nodrive: assert property (p_in_nodrive) else $error("input pin driven"); // R5

    property p_pp_drive;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (dir_reg[0] && mode_reg[0] && !ALT_OUT_EN[0])
            |=> (PIN_OE[0] && PIN_OUT[0] == $past(level_reg[0]));
    endproperty
    a_pp_drive: assert property (p_pp_drive) else $error("push-pull drive wrong"); // R11

    property p_od_float;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (dir_reg[0] && !mode_reg[0] && level_reg[0] && !ALT_OUT_EN[0]) |=> !PIN_OE[0];
    endproperty
    a_od_float: assert property (p_od_float) else $error("open-drain high driven"); // R12

    property p_alt_over;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ALT_OUT_EN[0] |=> (PIN_OUT[0] == $past(ALT_OUT[0]));
    endproperty
    a_alt_over: assert property (p_alt_over) else $error("alternate not driving"); // R13

    property p_irq_set;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (any_ev && !sense_chg) |=> EXT_IRQ;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event lost"); // R8

    property p_irq_cancel;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        sense_chg |=> !EXT_IRQ;
    endproperty
    a_irq_cancel: assert property (p_irq_cancel) else $error("request not discarded"); // R10

    property p_irq_fetch;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (VEC_FETCH && !any_ev) |=> !EXT_IRQ;
    endproperty
    a_irq_fetch: assert property (p_irq_fetch) else $error("fetch did not clear"); // R9

    sequence s_level_read;
        RD && ADDR == ADDR_LEVEL;
    endsequence

    sequence s_pending;
        EXT_IRQ && !sense_chg;
    endsequence

    sequence s_no_fetch;
        !VEC_FETCH;
    endsequence

    property p_irq_hold;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        s_pending ##0 s_no_fetch |=> EXT_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped early"); // R9

    property p_sync;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ARST_N |-> ##2 (sync2_reg == $past(PIN_IN, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("pin sync path wrong"); // R22

    property p_pullup;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (!dir_reg[0] && !ALT_OUT_EN[0]) |=> (PIN_PULLUP[0] == $past(mode_reg[0]));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up select wrong"); // R5

    property p_alt_drive;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ALT_OUT_EN[0] |=> (PIN_OE[0] == !($past(ALT_OPEN_DRAIN[0]) && $past(ALT_OUT[0])));
    endproperty
    a_alt_drive: assert property (p_alt_drive) else $error("peripheral drive wrong"); // R14

    property p_alt_feed;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (dir_reg[0] && ALT_IN_EN[0]) |=> (ALT_IN[0] == $past(level_reg[0]));
    endproperty
    a_alt_feed: assert property (p_alt_feed) else $error("peripheral input wrong"); // R17

    property p_rd_alt;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        s_level_read ##0 (!dir_reg[0] && ALT_OUT_EN[0]) |=> (RDATA[0] == $past(ALT_OUT[0]));
    endproperty
    a_rd_alt: assert property (p_rd_alt) else $error("alternate readback wrong"); // R16
endmodule : gpp_port
`default_nettype wire

// [gpp_pkg.sv]
// package for the eight-pin port block
package gpp_pkg;
    localparam int PIN_W = 8;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_DIR = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_SENSE = 2'h3;
    localparam logic [PIN_W-1:0] RST_PORT = 8'h00;
    localparam logic [1:0] RST_SENSE = 2'h0;
    localparam logic [PIN_W-1:0] IRQ_CAPABLE = 8'hFF;
    localparam int SENSE_W = 2;
    typedef enum logic [1:0] {
        GPP_SENSE_FALL_LOW,
        GPP_SENSE_RISE,
        GPP_SENSE_FALL,
        GPP_SENSE_BOTH
    } gpp_sense_e;
endpackage : gpp_pkg

// [gpp_pins_model.sv]
// external circuitry seen at the eight port pins
`timescale 1ns/100ps
`default_nettype none
module gpp_pins_model (
    input wire logic clk,
    input wire logic [gpp_pkg::PIN_W-1:0] pin_out,
    input wire logic [gpp_pkg::PIN_W-1:0] pin_oe,
    input wire logic [gpp_pkg::PIN_W-1:0] pin_pullup,
    input wire logic [gpp_pkg::PIN_W-1:0] ext_drv,
    input wire logic [gpp_pkg::PIN_W-1:0] ext_en,
    output logic [gpp_pkg::PIN_W-1:0] pin_lvl
);
    import gpp_pkg::*;
    // ************************************************
    // wire resolution, undriven pins without pull-up flip every cycle
    // ************************************************
    logic [PIN_W-1:0] float_reg = 8'hA5;
    always_ff @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
        | (~pin_oe & ~ext_en & (pin_pullup | float_reg));
endmodule : gpp_pins_model
`default_nettype wire

// [gpp_port_tb.sv]
// self-checking testbench for the eight-pin port block
`timescale 1ns/100ps
`default_nettype none
module gpp_port_tb;
    import gpp_pkg::*;
    // ************************************************
    // clock, stimulus and instances
    // ************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fetch = 1'b0;
    logic irq;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, aen = 8'h00, aout = 8'h00, aod = 8'h00, aie = 8'h00;
    logic [7:0] ext = 8'hFF, ext_en = 8'hFF, rdata, pin_in, pin_out, pin_oe, pin_pu, ain;
    logic [7:0] d, dir, mode, lat, ae, ao, ad, ex, oe;
    logic [31:0] rnd = 32'hC353CFBB;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    initial forever #20 clk = ~clk;
    gpp_port i_dut (.SYS_CLK(clk), .ARST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_PULLUP(pin_pu), .ALT_OUT_EN(aen), .ALT_OUT(aout), .ALT_OPEN_DRAIN(aod),
        .ALT_IN_EN(aie), .ALT_IN(ain), .VEC_FETCH(fetch), .EXT_IRQ(irq));
    gpp_pins_model i_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pu), .ext_drv(ext), .ext_en(ext_en), .pin_lvl(pin_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic chk_irq(input logic e);
        chk({7'h00, irq}, {7'h00, e});
    endtask : chk_irq
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic pulse_fetch;
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
    endtask : pulse_fetch
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done;
        end
    end
    // ************************************************
    // test sequence
    // ************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int a = 0; a < 4; a++) begin
            rd_reg(a[1:0], d);
            chk(d, (a == 3) ? {6'h00, RST_SENSE} : (a == 0) ? ext : RST_PORT);
        end
        wr_reg(ADDR_SENSE, 8'hFF);
        rd_reg(ADDR_SENSE, d);
        chk(d, 8'h03);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            dir = rnd[7:0];
            mode = rnd[15:8];
            lat = rnd[23:16];
            rnd = lfsr(rnd);
            wr_reg(ADDR_LEVEL, lat);
            wr_reg(ADDR_MODE, mode);
            wr_reg(ADDR_DIR, dir);
            ae = rnd[7:0] & (dir | ~mode);
            ao = rnd[15:8];
            ad = rnd[23:16];
            ex = rnd[31:24];
            oe = (ae & (~ad | ~ao)) | (~ae & dir & (mode | ~lat));
            aen <= ae;
            aout <= ao;
            aod <= ad;
            aie <= ~ex;
            ext <= ex;
            ext_en <= ~oe;
            repeat (5) @(posedge clk);
            chk(pin_oe, oe);
            chk(pin_out & oe, ((ae & ao) | (~ae & lat)) & oe);
            chk(pin_pu, ~dir & mode & ~ae);
            chk(ain, (dir & lat) | (~dir & ((oe & ao) | (~oe & ex))));
            rd_reg(ADDR_LEVEL, d);
            chk(d, (dir & lat) | (~dir & ae & ao) | (~dir & ~ae & ex));
            rd_reg(ADDR_DIR, d);
            chk(d, dir);
        end
        $display("test pins done");
        @(posedge clk);
        aen <= 8'h00;
        ext_en <= 8'hFF;
        ext <= 8'hFF;
        wr_reg(ADDR_DIR, 8'h00);
        wr_reg(ADDR_MODE, 8'h08);
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_SENSE, s[7:0]);
            ext <= 8'hF7;
            repeat (5) @(posedge clk);
            pulse_fetch;
            ext <= 8'hFF;
            repeat (5) @(posedge clk);
            chk_irq(s != 2);
            pulse_fetch;
            repeat (2) @(posedge clk);
            chk_irq(1'b0);
            ext <= 8'hDF;
            repeat (5) @(posedge clk);
            ext <= 8'hFF;
            repeat (5) @(posedge clk);
            chk_irq(1'b0);
            ext <= 8'hF7;
            repeat (5) @(posedge clk);
            chk_irq(s != 1);
            ext <= 8'hFF;
            repeat (4) @(posedge clk);
            wr_reg(ADDR_SENSE, s[7:0]);
            repeat (2) @(posedge clk);
            chk_irq(1'b1);
            wr_reg(ADDR_SENSE, s[7:0] ^ 8'h01);
            repeat (2) @(posedge clk);
            chk_irq(1'b0);
        end
        $display("test interrupt done");
        test_done;
    end
endmodule : gpp_port_tb
`default_nettype wire
